/* File: tm16_timer.v */
// Purpose: 16-bit timer/event counter with two capture/compare registers,
//          two filtered edge inputs and an AXI4-Lite register slave.
// Assumes: Edge inputs are asynchronous pins; aclk is the main oscillator.
// Notes:   Count clock is a divided square wave derived from aclk, or the edges of edge_input_a.
//
// Overview of operation
// - A capture that meets a read of the same register still happens.
// - Reading the counter never loads capcmp_reg_b.
// - While stopped, both edge inputs are ignored.
// - One-shot output works only in free-running and edge-clear modes.
// - With edge_input_a as count clock, it triggers no capture.
// - The capture register loads on the falling edge of the count clock.
// - The capture interrupt rises on the next count clock rising edge.
// - A register in compare mode does not capture.
// - A high input after reset gives a rising edge at first enable.
// - A high input at re-enable after a stop gives no rising edge.
// - edge_input_a is filtered by aclk as count clock, else by prescaler.
// - A capture starts only after two equal samples of the valid edge.
// - Bits 5:4 of prescaler_select_reg choose the edge of edge_input_a.
// - Mode bits 00 stop the counter; any other value runs it.
`timescale 1ns/1ps
`include "tm16_map.vh"

module tm16_timer
(
	// Clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// AXI4-Lite write address
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Edge input pins
	input  wire        edge_input_a,
	input  wire        edge_input_b,
	// Outputs
	output reg         one_shot_out,
	output reg         irq
);

	// Registers
	reg [7:0]  mode_control_reg;
	reg [7:0]  prescaler_select_reg;
	reg [1:0]  capcmp_ctrl;
	reg [15:0] count_reg16;
	reg [15:0] capcmp_reg_a;
	reg [15:0] capcmp_reg_b;
	reg [2:0]  status;
	reg [2:0]  mask;

	// Pin synchronisers
	reg [1:0] sync_a;
	reg [1:0] sync_b;

	// Prescaler
	reg [4:0] presc_cnt;
	reg       presc_phase;
	reg       presc_rise;
	reg       presc_fall;
	reg       ext_fall;

	// Pending events
	reg cap_pend_a;
	reg cap_pend_b;
	reg irq_pend_a;
	reg irq_pend_b;
	reg clr_pend;
	reg osp_armed;

	// AXI state
	reg [7:0]  aw_addr;
	reg        aw_have;
	reg [31:0] w_data;
	reg [3:0]  w_strb;
	reg        w_have;

	wire [1:0] mode;
	wire [1:0] clk_sel;
	wire       running;
	wire       ext_clk;
	wire       osp_mode;
	wire       edge_a_evt;
	wire       edge_b_evt;
	wire       rise_p;
	wire       fall_p;
	wire [4:0] half_period;
	wire       wr_go;
	wire       wr_ok;
	wire       rd_go;
	wire       cap_a_now;
	wire       cap_b_now;
	wire       match_a;
	wire       match_b;
	wire       ospt_wr;
	wire [2:0] set_vec;

	assign mode     = mode_control_reg[`TM16_MODE_LSB +: 2];
	assign clk_sel  = prescaler_select_reg[`TM16_CLKSEL_LSB +: 2];
	assign running  = (mode != `TM16_MODE_STOP);
	assign ext_clk  = (clk_sel == `TM16_CLKSEL_EXT);
	assign osp_mode = (mode == `TM16_MODE_FREE) |
		(mode == `TM16_MODE_EDGECLR);
	assign half_period = (clk_sel == 2'h0) ? 5'h01 :
		(clk_sel == 2'h1) ? 5'h04 : 5'h10;
	assign rise_p = ext_clk ? edge_a_evt : presc_rise;
	assign fall_p = ext_clk ? ext_fall : presc_fall;

	// Edge detectors; stopping the counter gates both
	tm16_edge_det u_edge_a
	(
		.clk        (aclk),
		.rstn       (aresetn),
		.level_in   (sync_a[1]),
		.sample     (ext_clk | presc_rise),
		.enable     (running),
		.edge_sel   (prescaler_select_reg[`TM16_EDGE_A_LSB +: 2]),
		.edge_pulse (edge_a_evt)
	);

	tm16_edge_det u_edge_b
	(
		.clk        (aclk),
		.rstn       (aresetn),
		.level_in   (sync_b[1]),
		.sample     (presc_rise),
		.enable     (running),
		.edge_sel   (prescaler_select_reg[`TM16_EDGE_B_LSB +: 2]),
		.edge_pulse (edge_b_evt)
	);

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sync_a <= 2'h0;
			sync_b <= 2'h0;
		end
		else
		begin
			sync_a <= {sync_a[0], edge_input_a};
			sync_b <= {sync_b[0], edge_input_b};
		end
	end

	// Prescaler square wave; free-running so sampling never stalls
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			presc_cnt   <= 5'h00;
			presc_phase <= 1'b0;
			presc_rise  <= 1'b0;
			presc_fall  <= 1'b0;
			ext_fall    <= 1'b0;
		end
		else
		begin
			presc_rise <= 1'b0;
			presc_fall <= 1'b0;
			ext_fall   <= ext_clk & edge_a_evt;
			if (presc_cnt >= half_period - 5'h01)
			begin
				presc_cnt   <= 5'h00;
				presc_phase <= ~presc_phase;
				presc_rise  <= ~presc_phase;
				presc_fall  <= presc_phase;
			end
			else
				presc_cnt <= presc_cnt + 5'h01;
		end
	end

	// AXI handshake decode
	assign wr_go = aw_have & w_have & ~s_axi_bvalid;
	assign wr_ok = (aw_addr <= `TM16_OFS_MASK) & (aw_addr[1:0] == 2'h0)
		& (aw_addr != `TM16_OFS_COUNT) & (aw_addr != `TM16_OFS_STATUS);
	assign rd_go = s_axi_arvalid & s_axi_arready;
	assign ospt_wr = wr_go & (aw_addr == `TM16_OFS_OSPT)
		& w_strb[0] & w_data[0];

	// Capture occurs on the count clock falling edge
	assign cap_a_now = fall_p & cap_pend_a;
	assign cap_b_now = fall_p & cap_pend_b;
	assign match_a = rise_p & running & ~capcmp_ctrl[`TM16_CAPA_BIT]
		& (count_reg16 == capcmp_reg_a);
	assign match_b = rise_p & running & ~capcmp_ctrl[`TM16_CAPB_BIT]
		& (count_reg16 == capcmp_reg_b);

	// Status set sources; capture interrupts wait for the next rise
	assign set_vec[`TM16_ST_A] = match_a | (rise_p & irq_pend_a);
	assign set_vec[`TM16_ST_B] = match_b | (rise_p & irq_pend_b);
	assign set_vec[`TM16_ST_OVF] = rise_p & running & ~clr_pend
		& (count_reg16 == 16'hFFFF);

	// Counter, captures and one-shot output
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			count_reg16  <= `TM16_REG16_RST;
			capcmp_reg_a <= `TM16_REG16_RST;
			capcmp_reg_b <= `TM16_REG16_RST;
			cap_pend_a   <= 1'b0;
			cap_pend_b   <= 1'b0;
			irq_pend_a   <= 1'b0;
			irq_pend_b   <= 1'b0;
			clr_pend     <= 1'b0;
			osp_armed    <= 1'b0;
			one_shot_out <= 1'b0;
		end
		else
		begin
			// Capture triggers; compare-mode registers ignore them
			if (cap_a_now)
				cap_pend_a <= 1'b0;
			if (edge_b_evt & capcmp_ctrl[`TM16_CAPA_BIT])
				cap_pend_a <= 1'b1;
			if (cap_b_now)
				cap_pend_b <= 1'b0;
			if (edge_a_evt & ~ext_clk
				& capcmp_ctrl[`TM16_CAPB_BIT])
				cap_pend_b <= 1'b1;
			// Capture outranks any bus access to the same register
			if (cap_a_now)
				capcmp_reg_a <= count_reg16;
			else if (wr_go & (aw_addr == `TM16_OFS_CAPA))
				capcmp_reg_a <= w_data[15:0];
			if (cap_b_now)
				capcmp_reg_b <= count_reg16;
			else if (wr_go & (aw_addr == `TM16_OFS_CAPB))
				capcmp_reg_b <= w_data[15:0];
			if (cap_a_now)
				irq_pend_a <= 1'b1;
			else if (rise_p)
				irq_pend_a <= 1'b0;
			if (cap_b_now)
				irq_pend_b <= 1'b1;
			else if (rise_p)
				irq_pend_b <= 1'b0;
			// Clear-and-start requests apply at the next count rise
			if ((edge_a_evt & (mode == `TM16_MODE_EDGECLR))
				| (ospt_wr & osp_mode & running))
				clr_pend <= 1'b1;
			else if (rise_p)
				clr_pend <= 1'b0;
			if (!running)
				count_reg16 <= `TM16_REG16_RST;
			else if (rise_p)
			begin
				if (clr_pend)
					count_reg16 <= `TM16_REG16_RST;
				else if ((mode == `TM16_MODE_MATCH)
					& (count_reg16 == capcmp_reg_a))
					count_reg16 <= `TM16_REG16_RST;
				else
					count_reg16 <= count_reg16 + 16'h0001;
			end
			// One-shot: active at match b, inactive at match a
			if (!osp_mode | !mode_control_reg[`TM16_OSP_EN_BIT])
			begin
				osp_armed    <= 1'b0;
				one_shot_out <= 1'b0;
			end
			else if (rise_p & clr_pend)
				osp_armed <= 1'b1;
			else if (osp_armed & match_b)
				one_shot_out <= 1'b1;
			else if (osp_armed & one_shot_out & match_a)
			begin
				one_shot_out <= 1'b0;
				osp_armed    <= 1'b0;
			end
		end
	end

	// AXI4-Lite slave and control registers
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready        <= 1'b0;
			s_axi_wready         <= 1'b0;
			s_axi_bvalid         <= 1'b0;
			s_axi_bresp          <= `TM16_RESP_OKAY;
			s_axi_arready        <= 1'b0;
			s_axi_rvalid         <= 1'b0;
			s_axi_rresp          <= `TM16_RESP_OKAY;
			s_axi_rdata          <= 32'h00000000;
			aw_addr              <= 8'h00;
			aw_have              <= 1'b0;
			w_data               <= 32'h00000000;
			w_strb               <= 4'h0;
			w_have               <= 1'b0;
			mode_control_reg     <= `TM16_MODE_RST;
			prescaler_select_reg <= `TM16_PRESC_RST;
			capcmp_ctrl          <= `TM16_CAPCTL_RST;
			status               <= `TM16_STATUS_RST;
			mask                 <= `TM16_MASK_RST;
			irq                  <= 1'b0;
		end
		else
		begin
			s_axi_awready <= ~aw_have & ~s_axi_awready & s_axi_awvalid;
			if (s_axi_awvalid & s_axi_awready)
			begin
				aw_addr <= s_axi_awaddr;
				aw_have <= 1'b1;
			end
			s_axi_wready <= ~w_have & ~s_axi_wready & s_axi_wvalid;
			if (s_axi_wvalid & s_axi_wready)
			begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				w_have <= 1'b1;
			end
			if (wr_go)
			begin
				aw_have      <= 1'b0;
				w_have       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_ok | (aw_addr == `TM16_OFS_STATUS))
					? `TM16_RESP_OKAY : `TM16_RESP_SLVERR;
				if (w_strb[0])
				begin
					case (aw_addr)
					`TM16_OFS_MODE:   mode_control_reg <= w_data[7:0];
					`TM16_OFS_PRESC:  prescaler_select_reg <= w_data[7:0];
					`TM16_OFS_CAPCTL: capcmp_ctrl <= w_data[1:0];
					`TM16_OFS_MASK:   mask <= w_data[2:0];
					default:          ;
					endcase
				end
			end
			else if (s_axi_bvalid & s_axi_bready)
				s_axi_bvalid <= 1'b0;

			// Reads take one cycle; status clears on read, sets win
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
			status <= status | set_vec;
			if (rd_go)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `TM16_RESP_OKAY;
				s_axi_rdata  <= 32'h00000000;
				case (s_axi_araddr)
				`TM16_OFS_MODE:   s_axi_rdata[7:0] <= mode_control_reg;
				`TM16_OFS_PRESC:  s_axi_rdata[7:0] <= prescaler_select_reg;
				`TM16_OFS_CAPCTL: s_axi_rdata[1:0] <= capcmp_ctrl;
				// Plain snapshot; no side effect on capcmp_reg_b
				`TM16_OFS_COUNT:  s_axi_rdata[15:0] <= count_reg16;
				`TM16_OFS_CAPA:   s_axi_rdata[15:0] <= capcmp_reg_a;
				`TM16_OFS_CAPB:   s_axi_rdata[15:0] <= capcmp_reg_b;
				`TM16_OFS_OSPT:   s_axi_rdata <= 32'h00000000;
				`TM16_OFS_STATUS:
				begin
					s_axi_rdata[2:0] <= status;
					status <= set_vec;
				end
				`TM16_OFS_MASK:   s_axi_rdata[2:0] <= mask;
				default:          s_axi_rresp <= `TM16_RESP_SLVERR;
				endcase
			end
			else if (s_axi_rvalid & s_axi_rready)
				s_axi_rvalid <= 1'b0;

			irq <= |(status & mask);
		end
	end

endmodule

/* File: tm16_map.vh */
// Purpose: Register map, field positions and reset values of the
//          16-bit capture/compare timer.
// Assumes: AXI4-Lite byte addresses, one 32-bit word per register.
// Notes:   Definitions only.
`ifndef TM16_MAP_VH
`define TM16_MAP_VH

// Register byte offsets
`define TM16_OFS_MODE     8'h00
`define TM16_OFS_PRESC    8'h04
`define TM16_OFS_CAPCTL   8'h08
`define TM16_OFS_COUNT    8'h0C
`define TM16_OFS_CAPA     8'h10
`define TM16_OFS_CAPB     8'h14
`define TM16_OFS_OSPT     8'h18
`define TM16_OFS_STATUS   8'h1C
`define TM16_OFS_MASK     8'h20

// mode_control_reg fields
`define TM16_MODE_LSB     2
`define TM16_OSP_EN_BIT   0
`define TM16_MODE_STOP    2'h0
`define TM16_MODE_FREE    2'h1
`define TM16_MODE_EDGECLR 2'h2
`define TM16_MODE_MATCH   2'h3

// prescaler_select_reg fields
`define TM16_CLKSEL_LSB   0
`define TM16_EDGE_A_LSB   4
`define TM16_EDGE_B_LSB   6
`define TM16_CLKSEL_EXT   2'h3

// Edge select codes
`define TM16_EDGE_FALL    2'h0
`define TM16_EDGE_RISE    2'h1
`define TM16_EDGE_NONE    2'h2
`define TM16_EDGE_BOTH    2'h3

// capture/compare control fields (1 = capture mode)
`define TM16_CAPA_BIT     0
`define TM16_CAPB_BIT     1

// Status and mask bits
`define TM16_ST_A         0
`define TM16_ST_B         1
`define TM16_ST_OVF       2

// Reset values
`define TM16_MODE_RST     8'h00
`define TM16_PRESC_RST    8'h00
`define TM16_CAPCTL_RST   2'h0
`define TM16_REG16_RST    16'h0000
`define TM16_STATUS_RST   3'h0
`define TM16_MASK_RST     3'h0

// AXI responses
`define TM16_RESP_OKAY    2'h0
`define TM16_RESP_SLVERR  2'h2

`endif

/* File: tm16_edge_det.v */
// Purpose: Noise filter and valid-edge detector for one edge input.
// Assumes: level_in is already synchronised to clk.
// Notes:   Holds no edge history before the first enable.
`timescale 1ns/1ps
`include "tm16_map.vh"

module tm16_edge_det
(
	// Clock and reset
	input  wire       clk,
	input  wire       rstn,
	// Sampling
	input  wire       level_in,
	input  wire       sample,
	// Control
	input  wire       enable,
	input  wire [1:0] edge_sel,
	// Result
	output reg        edge_pulse
);

	reg last_sample;
	reg filt;
	reg prev;
	reg was_enabled;

	wire is_rise;
	wire is_fall;
	assign is_rise = filt & ~prev;
	assign is_fall = ~filt & prev;

	always @(posedge clk)
	begin
		if (!rstn)
		begin
			last_sample <= 1'b0;
			filt        <= 1'b0;
			prev        <= 1'b0;
			was_enabled <= 1'b0;
			edge_pulse  <= 1'b0;
		end
		else
		begin
			edge_pulse <= 1'b0;
			if (sample)
			begin
				last_sample <= level_in;
				// Two equal samples needed, so a short glitch never lands
				if (last_sample == level_in)
					filt <= level_in;
			end
			if (enable)
			begin
				was_enabled <= 1'b1;
				prev        <= filt;
				case (edge_sel)
				`TM16_EDGE_FALL: edge_pulse <= is_fall;
				`TM16_EDGE_RISE: edge_pulse <= is_rise;
				`TM16_EDGE_BOTH: edge_pulse <= is_rise | is_fall;
				default:         edge_pulse <= 1'b0;
				endcase
			end
			else if (was_enabled)
				// Track the pin while stopped so a high level is no edge
				prev <= filt;
		end
	end

endmodule

/* File: tm16_props.sv */
// Purpose: Port checks for tm16_timer.
// Assumes: Mode is tracked from bus writes.
// Notes:   Tracked mode lags the register by one cycle, as outputs do.
`timescale 1ns/1ps
`include "tm16_map.vh"

module tm16_props
(
	// Clock and reset
	input wire        aclk,
	input wire        aresetn,
	// Write side
	input wire [7:0]  s_axi_awaddr,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	// Read side
	input wire [7:0]  s_axi_araddr,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0]  s_axi_rresp,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	// Outputs
	input wire        one_shot_out,
	input wire        irq
);
	reg [7:0] wa;
	reg [1:0] wm;
	reg [1:0] md;
	reg       bq;
	always @(posedge aclk)
	begin
		bq <= s_axi_bvalid;
		if (!aresetn)
			md <= `TM16_MODE_STOP;
		else if (s_axi_bvalid && !bq && wa == `TM16_OFS_MODE)
			md <= wm;
		if (s_axi_awvalid && s_axi_awready)
			wa <= s_axi_awaddr;
		if (s_axi_wvalid && s_axi_wready)
			wm <= s_axi_wdata[3:2];
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_b_held: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
	chk_r_held: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
	chk_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready longer than one cycle");
	chk_w_pulse: assert property (s_axi_wready |=> !s_axi_wready)
		else $error("wready longer than one cycle");
	chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid) else $error("read answer late");
	chk_count_ro: assert property ($rose(s_axi_bvalid) && wa ==
		`TM16_OFS_COUNT |-> s_axi_bresp == `TM16_RESP_SLVERR)
		else $error("counter write accepted");
	chk_bad_read: assert property (s_axi_arvalid && s_axi_arready &&
		s_axi_araddr > `TM16_OFS_MASK |=> s_axi_rresp == `TM16_RESP_SLVERR
		&& s_axi_rdata == 32'h0) else $error("unmapped read answered");
	chk_osp_mode: assert property ($rose(one_shot_out) |->
		md == `TM16_MODE_FREE || md == `TM16_MODE_EDGECLR)
		else $error("one-shot in wrong mode");
	cov_irq: cover property ($rose(irq));
	cov_osp: cover property ($rose(one_shot_out));
	cov_err: cover property (s_axi_bvalid && s_axi_bresp == `TM16_RESP_SLVERR);
endmodule

bind tm16_timer tm16_props i_props (.aclk, .aresetn, .s_axi_awaddr,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .one_shot_out, .irq);

/* File: tm16_src.sv */
// Purpose: External trigger source on the two edge pins.
// Assumes: Push-pull drivers, so a pin always shows its level.
// Notes:   Widths are set by the caller; short ones model noise.
`timescale 1ns/1ps

module tm16_src
(
	// Clock
	input wire aclk,
	// Edge pins
	output reg edge_input_a,
	output reg edge_input_b
);
	initial
	begin
		edge_input_a = 1'h0;
		edge_input_b = 1'h0;
	end
	task automatic set_pin(input bit ch, input bit lv);
	begin
		@(posedge aclk);
		if (ch)
			edge_input_b <= lv;
		else
			edge_input_a <= lv;
	end
	endtask
	// Level lv for n cycles, then back; an n of 1 models a glitch
	task automatic pulse(input bit ch, input bit lv, input int n);
	begin
		set_pin(ch, lv);
		repeat (n - 1) @(posedge aclk);
		set_pin(ch, !lv);
	end
	endtask
endmodule

/* File: tb.sv */
// Purpose: Self-checking bench for tm16_timer.
// Assumes: Edge pins come from tm16_src.
// Notes:   Bus results are checked from queues by a monitor.
`timescale 1ns/1ps
`include "tm16_map.vh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
	$display("unexpected %0t: got %0h want %0h", $time, a, b); end end

module tb;
	reg         aclk = 1'h0, aresetn = 1'h0;
	reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	reg  [31:0] s_axi_wdata = 32'h0;
	reg  [3:0]  s_axi_wstrb = 4'hF;
	reg         s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
	reg         s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire        s_axi_rvalid, edge_input_a, edge_input_b, one_shot_out, irq;
	wire [1:0]  s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	int         n_fail = 0, compares = 0;
	logic [1:0] exp_b[$], qb;
	logic [65:0] exp_r[$], q;
	logic [31:0] c0, c1, v, r;
	logic [1:0] ec[4] = '{`TM16_EDGE_FALL, `TM16_EDGE_RISE,
		`TM16_EDGE_BOTH, `TM16_EDGE_NONE};
	logic [31:0] en[4] = '{32'h1, 32'h1, 32'h2, 32'h0};
	logic [31:0] om[4] = '{32'h01, 32'h0D, 32'h05, 32'h09};
	logic        oe[4] = '{1'h0, 1'h0, 1'h1, 1'h1};
	always #12.5 aclk = ~aclk;
	tm16_timer i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .edge_input_a,
		.edge_input_b, .one_shot_out, .irq);
	tm16_src i_src (.aclk, .edge_input_a, .edge_input_b);
	task give_verdict;
	begin
		if (n_fail == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] e = `TM16_RESP_OKAY);
		logic aw;
		logic w;
	begin
		exp_b.push_back(e);
		aw = 1'h0;
		w = 1'h0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		while (!(aw && w))
		begin
			@(posedge aclk);
			aw = aw | s_axi_awready;
			w = w | s_axi_wready;
			if (aw)
				s_axi_awvalid <= 1'h0;
			if (w)
				s_axi_wvalid <= 1'h0;
		end
		// A late bready makes the slave hold its response
		repeat ($urandom % 3) @(posedge aclk);
		s_axi_bready <= 1'h1;
		do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
		s_axi_bready <= 1'h0;
	end
	endtask
	// A zero mask marks a read whose data is undefined
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m, output logic [31:0] d,
		input logic [1:0] re = `TM16_RESP_OKAY);
	begin
		exp_r.push_back({re, e & m, m});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do @(posedge aclk); while (s_axi_arready !== 1'h1);
		s_axi_arvalid <= 1'h0;
		repeat ($urandom % 3) @(posedge aclk);
		s_axi_rready <= 1'h1;
		do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
		d = s_axi_rdata;
		s_axi_rready <= 1'h0;
	end
	endtask
	// Waits up to n cycles for lv, then compares with ex
	task automatic wt(input int n, input bit osp, input bit lv, input bit ex);
	begin
		repeat (n)
		begin
			@(posedge aclk);
			if ((osp ? one_shot_out : irq) === lv)
				break;
		end
		`CHK(osp ? one_shot_out : irq, ex)
	end
	endtask
	always @(posedge aclk)
	begin
		if (s_axi_bvalid && s_axi_bready)
		begin
			qb = exp_b.pop_front();
			`CHK(s_axi_bresp, qb)
		end
		if (s_axi_rvalid && s_axi_rready)
		begin
			q = exp_r.pop_front();
			`CHK({s_axi_rresp, s_axi_rdata & q[31:0]}, q[65:32])
		end
	end
	initial
	begin
		repeat (20000) @(posedge aclk);
		n_fail++;
		give_verdict;
	end
	initial
	begin
		r = $urandom(50659);
		i_src.set_pin(1'h0, 1'h1);
		repeat (11) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		for (int i = 0; i < 9; i++)
			rd(8'(i * 4), 32'h0, 32'hFFFFFFFF, v);
		rd(8'h24, 32'h0, 32'hFFFFFFFF, v, `TM16_RESP_SLVERR);
		wr(`TM16_OFS_COUNT, 32'h1, `TM16_RESP_SLVERR);
		wr(8'h24, 32'h1, `TM16_RESP_SLVERR);
		// Pin high since reset; rise detect on the first start
		wr(`TM16_OFS_PRESC, 32'h90);
		wr(`TM16_OFS_CAPCTL, 32'h2);
		wr(`TM16_OFS_MASK, 32'h2);
		wr(`TM16_OFS_MODE, 32'h4);
		wt(100, 1'h0, 1'h1, 1'h1);
		rd(`TM16_OFS_STATUS, 32'h2, 32'h2, v);
		wt(10, 1'h0, 1'h0, 1'h0);
		wr(`TM16_OFS_MODE, 32'h0);
		i_src.pulse(1'h0, 1'h0, 20);
		// Let the filter settle, so the pin is high and not rising
		repeat (10) @(posedge aclk);
		wr(`TM16_OFS_MODE, 32'h4);
		wt(100, 1'h0, 1'h1, 1'h0);
		rd(`TM16_OFS_STATUS, 32'h0, 32'h2, v);
		// Capture while the register is being read, interrupt masked
		wr(`TM16_OFS_MASK, 32'h0);
		rd(`TM16_OFS_COUNT, 32'h0, 32'h0, c0);
		fork
			i_src.pulse(1'h0, 1'h0, 20);
			repeat (12) rd(`TM16_OFS_CAPB, 32'h0, 32'h0, v);
		join
		wt(60, 1'h0, 1'h1, 1'h0);
		rd(`TM16_OFS_CAPB, 32'h0, 32'h0, v);
		rd(`TM16_OFS_COUNT, 32'h0, 32'h0, c1);
		`CHK(v[15:0] > c0[15:0] && v[15:0] < c1[15:0], 1'h1)
		wr(`TM16_OFS_MASK, 32'h2);
		wt(5, 1'h0, 1'h1, 1'h1);
		rd(`TM16_OFS_STATUS, 32'h2, 32'h2, v);
		r = $urandom & 32'hFFFF;
		wr(`TM16_OFS_CAPCTL, 32'h0);
		wr(`TM16_OFS_CAPB, r);
		i_src.pulse(1'h0, 1'h0, 20);
		repeat (30) @(posedge aclk);
		rd(`TM16_OFS_CAPB, r, 32'hFFFF, v);
		// Edge of pin a as count clock, each polarity code
		wr(`TM16_OFS_CAPCTL, 32'h2);
		for (int i = 0; i < 4; i++)
		begin
			wr(`TM16_OFS_MODE, 32'h0);
			rd(`TM16_OFS_COUNT, 32'h0, 32'hFFFF, v);
			i_src.set_pin(1'h0, 1'h0);
			wr(`TM16_OFS_PRESC, {24'h0, 2'h2, ec[i], 4'h3});
			r = $urandom & 32'hFFFF;
			wr(`TM16_OFS_MODE, 32'h4);
			wr(`TM16_OFS_CAPB, r);
			i_src.pulse(1'h0, 1'h1, 20);
			repeat (10) @(posedge aclk);
			i_src.pulse(1'h0, 1'h1, 1);
			repeat (20) @(posedge aclk);
			rd(`TM16_OFS_COUNT, en[i], 32'hFFFF, v);
			rd(`TM16_OFS_CAPB, r, 32'hFFFF, v);
		end
		// Slow sampling clock: a glitch on pin b must not capture
		wr(`TM16_OFS_MODE, 32'h0);
		wr(`TM16_OFS_PRESC, 32'h62);
		wr(`TM16_OFS_CAPCTL, 32'h1);
		wr(`TM16_OFS_MASK, 32'h1);
		wr(`TM16_OFS_MODE, 32'h4);
		r = $urandom & 32'hFFFF;
		wr(`TM16_OFS_CAPA, r);
		rd(`TM16_OFS_STATUS, 32'h0, 32'h0, v);
		i_src.pulse(1'h1, 1'h1, 1);
		wt(200, 1'h0, 1'h1, 1'h0);
		rd(`TM16_OFS_CAPA, r, 32'hFFFF, v);
		i_src.pulse(1'h1, 1'h1, 80);
		wt(300, 1'h0, 1'h1, 1'h1);
		rd(`TM16_OFS_STATUS, 32'h1, 32'h1, v);
		// Software one-shot in stop, match, free and edge-clear modes
		wr(`TM16_OFS_MODE, 32'h0);
		wr(`TM16_OFS_PRESC, 32'hA0);
		wr(`TM16_OFS_CAPCTL, 32'h0);
		wr(`TM16_OFS_CAPB, 32'h4);
		wr(`TM16_OFS_CAPA, 32'h8);
		for (int i = 0; i < 4; i++)
		begin
			wr(`TM16_OFS_MODE, om[i]);
			wr(`TM16_OFS_OSPT, 32'h1);
			wt(200, 1'h1, 1'h1, oe[i]);
		end
		give_verdict;
	end
endmodule
